/* File: verilog/strap_pkg.sv */
// Purpose: shared constants and types for the strap sampling block
// Assumes: straps have board pull-ups, so an open pin reads high
// Notes: address prefix and strap layout are used by the top and its checks

package strap_pkg;

   // ****************************************
   // strap layout
   // ****************************************
   // one bit per dual-purpose pin, level as seen on the board
   typedef struct packed {
      logic smbus_n;   // low selects smbus mode
      logic port_led;  // port indicator strap
      logic gang;      // ganged / power led strap
      logic pwr_mgmt;  // full power management strap
   } strap_t;

   localparam strap_t STRAP_RESET = 4'hf;  // pull-up level before capture

   // ****************************************
   // smbus address
   // ****************************************
   localparam int ADDR_W = 7;
   localparam logic [3:0] ADDR_PREFIX = 4'h8;  // upper nibble 1000
   localparam logic [ADDR_W-1:0] ADDR_NONE = 7'h00;

   // ****************************************
   // capture timing
   // ****************************************
   // cycles the pin synchroniser needs after release before data are valid
   localparam logic [1:0] SETTLE_CYCLES = 2'h2;
   localparam logic [1:0] CNT_ONE = 2'h1;
   localparam logic [1:0] CNT_ZERO = 2'h0;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_CAPTURE = 2'b01,
      ST_HOLD = 2'b11
   } cap_state_t;

endpackage

/* File: verilog/pin_sync.sv */
// Purpose: two-stage synchroniser for the strap pins
// Assumes: pins are quasi-static levels from board resistors
// Notes: the first stage is read only by the second stage

`timescale 1ns/1ps

module pin_sync
   import strap_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // pins in, synchronised copy out
   input wire strap_t pins_i,
   output strap_t pins_o
);

   strap_t meta_reg;
   strap_t sync_reg;

   // reset to pull-up level so an idle board reads as undriven straps
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= STRAP_RESET;
         sync_reg <= STRAP_RESET;
      end else begin
         meta_reg <= pins_i;
         sync_reg <= meta_reg;
      end
   end

   assign pins_o = sync_reg;

endmodule

/* File: verilog/reset_strap_sampling.sv */
// Purpose: latch dual-purpose strap pins after reset and drive link status
// Assumes: 125 MHz clk_i; upstream mode and power request come from clk_i logic
// Notes: strap values are frozen until the next reset; pins are free after capture

`timescale 1ns/1ps

module reset_strap_sampling
   import strap_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // strap pins
   input wire logic power_mgmt_strap_addr_bit1_i,
   input wire logic gang_strap_addr_bit_i,
   input wire logic port_led_strap_addr_bit3_i,
   input wire logic smbus_mode_select_n_i,
   // hub core status and requests
   input wire logic upstream_superspeed_i,
   input wire logic port0_power_request_i,
   // status and power pins
   output logic superspeed_status_o,
   output logic port0_power_enable_n_o,
   // latched configuration
   output logic straps_valid_o,
   output logic full_power_mgmt_o,
   output logic power_led_enable_o,
   output logic port_led_enable_o,
   output logic smbus_mode_o,
   output logic [ADDR_W-1:0] smbus_addr_o
);

   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta_reg;
   logic rst_n;

   // assertion is asynchronous, release is aligned to clk_i
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ****************************************
   // pin synchroniser
   // ****************************************
   strap_t pins_raw;
   strap_t pins_s;

   assign pins_raw = '{smbus_n: smbus_mode_select_n_i,
                       port_led: port_led_strap_addr_bit3_i,
                       gang: gang_strap_addr_bit_i,
                       pwr_mgmt: power_mgmt_strap_addr_bit1_i};

   // held until the internal release, so the capture never sees a half-filled stage
   pin_sync u_pin_sync (
      .clk_i(clk_i),
      .arst_n_i(rst_n),
      .pins_i(pins_raw),
      .pins_o(pins_s)
   );

   // ****************************************
   // capture sequencer
   // ****************************************
   cap_state_t state_reg;
   cap_state_t state_next;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic settle_done;
   logic capture_now;

   // wait out the synchroniser so the first sample is a real pin level
   assign settle_done = (cnt_reg == SETTLE_CYCLES - CNT_ONE);
   assign capture_now = (state_reg == ST_CAPTURE);
   assign cnt_next = (state_reg == ST_WAIT) ? cnt_reg + CNT_ONE : CNT_ZERO;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_WAIT: begin
            if (settle_done) begin
               state_next = ST_CAPTURE;
            end
         end
         ST_CAPTURE: begin
            state_next = ST_HOLD;
         end
         ST_HOLD: begin
            state_next = ST_HOLD;
         end
         default: begin
            state_next = ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_WAIT;
         cnt_reg <= CNT_ZERO;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // ****************************************
   // strap latch
   // ****************************************
   strap_t straps_reg;
   strap_t straps_next;
   logic valid_reg;

   // freeze after capture
   // loaded only in the one capture cycle, so later pin activity is ignored
   assign straps_next = capture_now ? pins_s : straps_reg;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         straps_reg <= STRAP_RESET;
         valid_reg <= 1'b0;
      end else begin
         straps_reg <= straps_next;
         valid_reg <= valid_reg | capture_now;
      end
   end

   // ****************************************
   // decoded configuration
   // ****************************************
   logic [ADDR_W-1:0] addr_word;
   logic [ADDR_W-1:0] addr_next;
   logic pwr_next;

   // strap bits fill the low three address bits below the fixed 1000 prefix
   assign addr_word = {ADDR_PREFIX, straps_reg.port_led, straps_reg.gang,
                       straps_reg.pwr_mgmt};
   assign addr_next = (valid_reg && !straps_reg.smbus_n) ? addr_word : ADDR_NONE;

   // power switching
   // without full power management the port is simply held powered;
   // before capture the port stays off so it never glitches on
   assign pwr_next = !valid_reg ? 1'b1 :
                     !straps_reg.pwr_mgmt ? !port0_power_request_i : 1'b0;

   // registered outputs, all straps active low on the board
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         superspeed_status_o <= 1'b0;
         port0_power_enable_n_o <= 1'b1;
         straps_valid_o <= 1'b0;
         full_power_mgmt_o <= 1'b0;
         power_led_enable_o <= 1'b0;
         port_led_enable_o <= 1'b0;
         smbus_mode_o <= 1'b0;
         smbus_addr_o <= ADDR_NONE;
      end else begin
         superspeed_status_o <= upstream_superspeed_i;
         port0_power_enable_n_o <= pwr_next;
         straps_valid_o <= valid_reg;
         full_power_mgmt_o <= valid_reg & !straps_reg.pwr_mgmt;
         power_led_enable_o <= valid_reg & !straps_reg.gang;
         port_led_enable_o <= valid_reg & !straps_reg.port_led;
         smbus_mode_o <= valid_reg & !straps_reg.smbus_n;
         smbus_addr_o <= addr_next;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_capture;
      capture_now ##1 valid_reg;
   endsequence

   sequence s_outputs_up;
      s_capture ##1 straps_valid_o;
   endsequence

   // skip the first edge after release: the output was still held in reset there
   chk_ss_follow: assert property (
      $past(rst_n) |-> superspeed_status_o == $past(upstream_superspeed_i))
      else $error("superspeed status does not follow upstream mode");

   chk_capture_time: assert property (
      $rose(rst_n) |-> ##[1:5] straps_valid_o)
      else $error("straps not captured in time after release");

   // the capture edge lies two edges before the decoded outputs are seen
   chk_pm_level: assert property (
      s_outputs_up |-> full_power_mgmt_o == !$past(pins_s.pwr_mgmt, 2))
      else $error("full power management does not match strap");

   chk_power_gate: assert property (
      straps_valid_o && full_power_mgmt_o && $stable(full_power_mgmt_o)
      |=> port0_power_enable_n_o == !$past(port0_power_request_i))
      else $error("port power does not follow request");

   chk_led_levels: assert property (
      s_outputs_up |-> power_led_enable_o == !$past(pins_s.gang, 2))
      else $error("power led enable does not match strap");

   chk_port_led: assert property (
      s_outputs_up |-> port_led_enable_o == !$past(pins_s.port_led, 2))
      else $error("port led enable does not match strap");

   chk_addr_bit1: assert property (
      smbus_mode_o |-> smbus_addr_o[0] == !full_power_mgmt_o)
      else $error("address bit one differs from power strap");

   chk_addr_bit2: assert property (
      smbus_mode_o |-> smbus_addr_o[1] == !power_led_enable_o)
      else $error("address bit two differs from ganged strap");

   chk_addr_bit3: assert property (
      smbus_mode_o |-> smbus_addr_o[2] == !port_led_enable_o)
      else $error("address bit three differs from port strap");

   chk_addr_prefix: assert property (
      smbus_mode_o |-> smbus_addr_o[ADDR_W-1:3] == ADDR_PREFIX)
      else $error("address prefix is not 1000");

   chk_straps_frozen: assert property (
      straps_valid_o |=> $stable(straps_reg) && $stable(smbus_addr_o))
      else $error("latched straps changed after capture");

endmodule

/* File: verif/strap_board.sv */
// Purpose: board strap resistors seen by the hub strap pins
// Assumes: every strap pin has a pull-up; the bench may drive any pin low or high
// Notes: an undriven pin rests at its pull-up level, never at its last driven value

`timescale 1ns/1ps

module strap_board
   import strap_pkg::*;
(
   // bench control
   input wire strap_t drive_en_i,
   input wire strap_t drive_val_i,
   // pin levels
   output strap_t pins_o
);
   // ****************************************
   // pull-up resolution
   // ****************************************
   // released straps read one
   assign pins_o = strap_t'((drive_en_i & drive_val_i) | ~drive_en_i);
endmodule

/* File: verif/reset_strap_sampling_tb.sv */
// Purpose: self-checking bench for strap capture, address, status and port power
// Assumes: inputs change 1 ns after the rising edge; straps settle before release
// Notes: each round resets with new straps, then scrambles pins to prove they are frozen

`timescale 1ns/1ps

module reset_strap_sampling_tb;
   import strap_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   strap_t drv_en = '0;
   strap_t drv_val = '0;
   strap_t pins;
   strap_t cur;
   logic ss_in = 1'b0;
   logic req = 1'b0;
   logic ss_o, pwr_n_o, valid_o, fpm_o, pled_o, portled_o, smb_o;
   logic [ADDR_W-1:0] addr_o;
   logic [31:0] r;
   int error_cnt = 0;
   int cmp_count = 0;
   int seed = 32'h13412082;
   int n;

   // 125 mhz clock
   always #4 clk_i = ~clk_i;

   strap_board board (.drive_en_i(drv_en), .drive_val_i(drv_val), .pins_o(pins));

   reset_strap_sampling uut (
      .clk_i(clk_i), .arst_n_i(arst_n_i),
      .power_mgmt_strap_addr_bit1_i(pins.pwr_mgmt), .gang_strap_addr_bit_i(pins.gang),
      .port_led_strap_addr_bit3_i(pins.port_led), .smbus_mode_select_n_i(pins.smbus_n),
      .upstream_superspeed_i(ss_in), .port0_power_request_i(req),
      .superspeed_status_o(ss_o), .port0_power_enable_n_o(pwr_n_o),
      .straps_valid_o(valid_o), .full_power_mgmt_o(fpm_o), .power_led_enable_o(pled_o),
      .port_led_enable_o(portled_o), .smbus_mode_o(smb_o), .smbus_addr_o(addr_o));

   // ****************************************
   // compare and report
   // ****************************************
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic cmp_addr(input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch smbus_addr expected %h seen %h", exp, got);
      end
   endtask

   // address follows the straps only in smbus mode
   function automatic logic [ADDR_W-1:0] exp_addr(input strap_t s);
      return s.smbus_n ? ADDR_NONE : {ADDR_PREFIX, s.port_led, s.gang, s.pwr_mgmt};
   endfunction

   task automatic print_verdict();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // one reset round
   // ****************************************
   // straps are held until valid, then scrambled so a live decode would show
   task automatic run_round(input strap_t en, input strap_t val);
      int i;
      logic ssp;
      logic prq;
      @(posedge clk_i);
      #1;
      arst_n_i = 1'b0;
      drv_en = en;
      drv_val = val;
      cur = strap_t'((en & val) | ~en);
      repeat (20) @(posedge clk_i);
      #1;
      cmp_bit("power_off_in_reset", 1'b1, pwr_n_o);
      cmp_bit("valid_in_reset", 1'b0, valid_o);
      arst_n_i = 1'b1;
      i = 0;
      while (valid_o !== 1'b1 && i < 20) begin
         @(posedge clk_i);
         #1;
         i++;
      end
      if (valid_o !== 1'b1) begin
         error_cnt++;
         $display("mismatch straps_valid expected 1 seen %b", valid_o);
         print_verdict();
      end
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         ss_in = r[0];
         req = r[1];
         ssp = r[0];
         prq = r[1];
         drv_en = '1;
         drv_val = strap_t'(r[5:2]);
         @(posedge clk_i);
         #1;
         cmp_bit("superspeed_status", ssp, ss_o);
         cmp_bit("port0_power_enable_n", cur.pwr_mgmt ? 1'b0 : ~prq, pwr_n_o);
         cmp_bit("full_power_mgmt", ~cur.pwr_mgmt, fpm_o);
         cmp_bit("power_led_enable", ~cur.gang, pled_o);
         cmp_bit("port_led_enable", ~cur.port_led, portled_o);
         cmp_bit("smbus_mode", ~cur.smbus_n, smb_o);
         cmp_addr(exp_addr(cur), addr_o);
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      run_round('1, '0);
      run_round('0, '0);
      run_round('1, strap_t'(4'h5));
      for (n = 0; n < 8; n++) begin
         r = $random(seed);
         run_round(strap_t'(r[3:0]), strap_t'(r[7:4]));
      end
      print_verdict();
   end
endmodule
